// ### core/obcd_field_decode.sv
// Pure field decoder from the two option bytes to configuration values
`timescale 1ns/1ns
module obcd_field_decode
  import obcd_pkg::*;
(
  // Option bytes
  input  wire logic [7:0]  byte0,
  input  wire logic [7:0]  byte1,
  // Decoded fields
  output logic             halt_reset_en,
  output logic             wdg_hw_enable,
  output logic             readout_protect,
  output logic             pkg_44pin,
  output logic [12:0]      delay_cycles,
  output logic [1:0]       clock_source_type,
  output logic [2:0]       oscillator_range,
  output logic             pll_enable
);
  always_comb begin
    halt_reset_en     = byte0[B0_HALT_RST_BIT];
    wdg_hw_enable     = ~byte0[B0_WDG_TYPE_BIT];
    readout_protect   = ~byte0[B0_ROP_BIT];
    pkg_44pin         = byte1[B1_PKG_BIT];
    delay_cycles      = byte1[B1_RESET_DELAY_LENGTH_SELECT_BIT] ? DELAY_SHORT : DELAY_LONG;
    clock_source_type = byte1[B1_OSC_HI:B1_OSC_LO];
    oscillator_range  = byte1[B1_RANGE_HI:B1_RANGE_LO];
    pll_enable        = ~byte1[B1_PLL_OFF_BIT];
  end
endmodule // obcd_field_decode

// ### core/obcd_option_byte_config_decoder.sv
// Option byte store, programming-mode access and static config decoder
`timescale 1ns/1ns
// Contract
// - Option bytes unmapped; accessible only in programming mode.
// - Erased program memory reads FFh in every byte.
// - Factory option bytes select an internal clock source.
// - Byte0 bit7 set: halt with active watchdog causes reset.
// - Byte0 bit6 clear: hardware watchdog; set: software enabled.
// - Byte0 bit0 clear enables read-out protection.
// - Protection blocks memory extraction and memory writes.
// - Erasing options under protection first erases all user memory.
// - Byte1 bit7: 1 selects 44-pin, 0 selects 32-pin.
// - Unbonded pads reset to input with pull-up.
// - Byte1 bit6: 0 gives 4096 cycles, 1 gives 256.
// - Byte1 bits 5:4: 00 resonator, 11 external, others reserved.
// - Mask ROM variant fixes configuration in hardware.
module obcd_option_byte_config_decoder
  import obcd_pkg::*;
#(
  parameter bit         MASK_ROM     = 1'b0,
  parameter logic [7:0] ROM_BYTE0    = FACTORY_BYTE0,
  parameter logic [7:0] ROM_BYTE1    = FACTORY_BYTE1,
  parameter int         MEM_ADDR_W   = 13,
  parameter int         NUM_PORTS    = 4
)(
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  // Programming-mode access from the external tool
  input  wire logic                    prog_mode,
  input  wire logic                    opt_wr,
  input  wire logic                    opt_sel,
  input  wire logic [7:0]              opt_wdata,
  input  wire logic                    opt_erase,
  output logic [7:0]                   opt_rdata,
  output logic                         opt_busy,
  // Program memory access gate
  input  wire logic                    mem_rd_ext,
  input  wire logic                    mem_wr_req,
  input  wire logic [7:0]              mem_rd_raw,
  output logic [7:0]                   mem_rd_data,
  output logic                         mem_wr_allow,
  output logic                         mem_erase,
  output logic [MEM_ADDR_W-1:0]        mem_erase_addr,
  output logic [7:0]                   mem_erase_data,
  // Halt and watchdog
  input  wire logic                    halt_entry,
  input  wire logic                    wdg_active,
  output logic                         halt_reset_req,
  // Static configuration
  output logic                         wdg_hw_enable,
  output logic                         pkg_44pin,
  output logic [12:0]                  reset_delay_cycles,
  output logic [1:0]                   clock_source_type,
  output logic [2:0]                   oscillator_range,
  output logic                         pll_enable,
  output logic                         readout_protect,
  output logic [NUM_PORTS*PADS_PER_PORT-1:0] pad_pullup_force
);
  // ==========================================================
  // Non-volatile store and reset-time shadow
  logic [7:0]            store0 = FACTORY_BYTE0;
  logic [7:0]            store1 = FACTORY_BYTE1;
  logic [7:0]            next_store0;
  logic [7:0]            next_store1;
  logic [7:0]            shadow0;
  logic [7:0]            shadow1;
  logic                  loaded;
  obcd_erase_t           state;
  obcd_erase_t           next_state;
  logic [MEM_ADDR_W-1:0] erase_addr;
  logic [MEM_ADDR_W-1:0] next_erase_addr;

  logic                  d_halt;
  logic                  d_wdg_hw;
  logic                  d_rop;
  logic                  d_pkg;
  logic [12:0]           d_delay;
  logic [1:0]            d_osc;
  logic [2:0]            d_range;
  logic                  d_pll;
  logic                  store_rop;

  assign store_rop = ~store0[B0_ROP_BIT];

  obcd_field_decode u_decode (
    .byte0             (shadow0),
    .byte1             (shadow1),
    .halt_reset_en     (d_halt),
    .wdg_hw_enable     (d_wdg_hw),
    .readout_protect   (d_rop),
    .pkg_44pin         (d_pkg),
    .delay_cycles      (d_delay),
    .clock_source_type (d_osc),
    .oscillator_range  (d_range),
    .pll_enable        (d_pll)
  );

  // ==========================================================
  // Programming-mode write and erase sequencing
  always_comb begin
    next_store0     = store0;
    next_store1     = store1;
    next_state      = state;
    next_erase_addr = erase_addr;
    unique case (state)
      OBCD_IDLE: begin
        if (!MASK_ROM && prog_mode) begin
          if (opt_erase) begin
            if (store_rop) begin
              next_state      = OBCD_ERASE_MEM;
              next_erase_addr = '0;
            end else begin
              next_state = OBCD_ERASE_OPT;
            end
          end else if (opt_wr) begin
            // Reserved bits are written as given; keeping them is the tool's job
            if (opt_sel) next_store1 = opt_wdata;
            else         next_store0 = opt_wdata;
          end
        end
      end
      // Protected erase walks every address before the options clear
      OBCD_ERASE_MEM: begin
        if (&erase_addr) next_state = OBCD_ERASE_OPT;
        else             next_erase_addr = erase_addr + 1'b1;
      end
      OBCD_ERASE_OPT: begin
        next_store0 = ERASED_BYTE;
        next_store1 = ERASED_BYTE;
        next_state  = OBCD_IDLE;
      end
    endcase
  end

  // Flash cells have no reset, so written options survive to the next reset
  // Start value is the shipped content; writes are ignored while reset is low
  always_ff @(posedge clk) begin
    if (rst_n) begin
      store0 <= next_store0;
      store1 <= next_store1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state      <= OBCD_IDLE;
      erase_addr <= '0;
    end else begin
      state      <= next_state;
      erase_addr <= next_erase_addr;
    end
  end

  // ==========================================================
  // Shadow capture on the first edge after reset release
  // Async reset may not load a signal, so the copy waits one edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shadow0 <= FACTORY_BYTE0;
      shadow1 <= FACTORY_BYTE1;
      loaded  <= 1'b0;
    end else if (!loaded) begin
      shadow0 <= MASK_ROM ? ROM_BYTE0 : store0;
      shadow1 <= MASK_ROM ? ROM_BYTE1 : store1;
      loaded  <= 1'b1;
    end
  end

  // ==========================================================
  // Registered outputs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      opt_rdata          <= 8'h00;
      opt_busy           <= 1'b0;
      mem_rd_data        <= 8'h00;
      mem_wr_allow       <= 1'b0;
      mem_erase          <= 1'b0;
      mem_erase_addr     <= '0;
      mem_erase_data     <= ERASED_BYTE;
      halt_reset_req     <= 1'b0;
      wdg_hw_enable      <= 1'b1;
      pkg_44pin          <= 1'b1;
      reset_delay_cycles <= DELAY_LONG;
      clock_source_type  <= OSC_INTERNAL;
      oscillator_range   <= RANGE_2_TO_4;
      pll_enable         <= 1'b0;
      readout_protect    <= 1'b1;
      pad_pullup_force   <= '1;
    end else begin
      // Unmapped bytes: nothing leaks outside programming mode
      opt_rdata <= (prog_mode && !MASK_ROM) ?
                   (opt_sel ? store1 : store0) : 8'h00;
      opt_busy  <= (next_state != OBCD_IDLE);
      // Protected external reads return the erased value, never content
      mem_rd_data  <= (mem_rd_ext && d_rop) ? ERASED_BYTE : mem_rd_raw;
      // Live store bit too, so a freshly protected part blocks at once
      mem_wr_allow <= mem_wr_req && !d_rop && !store_rop;
      mem_erase      <= (state == OBCD_ERASE_MEM);
      mem_erase_addr <= erase_addr;
      mem_erase_data <= ERASED_BYTE;
      // Waits for the shadow so stale options never fire a halt reset
      halt_reset_req <= halt_entry && wdg_active && d_halt && loaded;
      wdg_hw_enable      <= d_wdg_hw;
      pkg_44pin          <= d_pkg;
      reset_delay_cycles <= d_delay;
      clock_source_type  <= d_osc;
      oscillator_range   <= d_range;
      pll_enable         <= d_pll;
      readout_protect    <= d_rop;
      // Ports 0,1 fully bonded; pads 4-7 of ports 2,3 unbonded on 32-pin, all bonded on 44-pin
      for (int p = 0; p < NUM_PORTS*PADS_PER_PORT; p++) begin
        pad_pullup_force[p] <= !d_pkg && (p >= NUM_PORTS*PADS_PER_PORT/2)
                               && (p % PADS_PER_PORT >= PADS_PER_PORT/2);
      end
    end
  end
endmodule // obcd_option_byte_config_decoder

// ### core/obcd_pkg.sv
// Package: option byte layout, defaults and timing for the config decoder
package obcd_pkg;
  // ==========================================================
  // Byte 0 field positions
  localparam int B0_HALT_RST_BIT = 7;
  localparam int B0_WDG_TYPE_BIT = 6;
  localparam int B0_RSV_HI       = 5;
  localparam int B0_RSV_LO       = 1;
  localparam int B0_ROP_BIT      = 0;
  // ==========================================================
  // Byte 1 field positions
  localparam int B1_PKG_BIT      = 7;
  localparam int B1_RESET_DELAY_LENGTH_SELECT_BIT     = 6;
  localparam int B1_OSC_HI       = 5;
  localparam int B1_OSC_LO       = 4;
  localparam int B1_RANGE_HI     = 3;
  localparam int B1_RANGE_LO     = 1;
  localparam int B1_PLL_OFF_BIT  = 0;
  // ==========================================================
  // Encodings and values
  localparam logic [7:0] ERASED_BYTE    = 8'hff;
  localparam logic [1:0] OSC_RESONATOR  = 2'h0;
  localparam logic [1:0] OSC_EXTERNAL   = 2'h3;
  localparam logic [2:0] RANGE_1_TO_2   = 3'h0;
  localparam logic [2:0] RANGE_2_TO_4   = 3'h1;
  localparam logic [2:0] RANGE_4_TO_8   = 3'h2;
  localparam logic [2:0] RANGE_8_TO_16  = 3'h3;
  // Factory state: internal clock selected (reserved type code)
  localparam logic [7:0] FACTORY_BYTE0  = 8'hff;
  localparam logic [7:0] FACTORY_BYTE1  = 8'he7;
  localparam logic [1:0] OSC_INTERNAL   = 2'h2;
  // ==========================================================
  // Delay lengths in CPU cycles
  localparam logic [12:0] DELAY_LONG    = 13'h1000;
  localparam logic [12:0] DELAY_SHORT   = 13'h0100;
  localparam int          PADS_PER_PORT = 8;
  typedef enum logic [1:0] {
    OBCD_IDLE, OBCD_ERASE_MEM, OBCD_ERASE_OPT
  } obcd_erase_t;
endpackage

// ### verification/obcd_checker.sv
// Port checker for the option byte config decoder
`timescale 1ns/1ns
module obcd_checker
  import obcd_pkg::*;
#(
  parameter int MEM_ADDR_W = 13,
  parameter int NUM_PORTS  = 4
)(
  // Clock, reset, option port
  input wire logic                  clk,
  input wire logic                  rst_n,
  input wire logic                  prog_mode,
  input wire logic [7:0]            opt_rdata,
  input wire logic                  opt_busy,
  // Memory gate and halt
  input wire logic                  mem_rd_ext,
  input wire logic [7:0]            mem_rd_data,
  input wire logic                  mem_wr_allow,
  input wire logic                  mem_erase,
  input wire logic [MEM_ADDR_W-1:0] mem_erase_addr,
  input wire logic [7:0]            mem_erase_data,
  input wire logic                  halt_entry,
  input wire logic                  wdg_active,
  input wire logic                  halt_reset_req,
  // Static configuration
  input wire logic                  wdg_hw_enable,
  input wire logic                  pkg_44pin,
  input wire logic [12:0]           reset_delay_cycles,
  input wire logic [1:0]            clock_source_type,
  input wire logic [2:0]            oscillator_range,
  input wire logic                  pll_enable,
  input wire logic                  readout_protect,
  input wire logic [NUM_PORTS*PADS_PER_PORT-1:0] pad_pullup_force
);
  // Config outputs are only meaningful from the second edge after release
  logic [1:0] age;
  logic [1:0] next_age;
  always_comb begin
    next_age = (age == 2'h3) ? age : age + 2'h1;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) age <= 2'h0;
    else age <= next_age;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_halt_cause: assert property (halt_reset_req |-> $past(halt_entry && wdg_active))
    else $error("halt reset without halt under active watchdog");
  a_rdata_closed: assert property (!prog_mode |=> opt_rdata == 8'h00)
    else $error("option byte visible outside programming mode");
  a_read_blocked: assert property (age[1] && mem_rd_ext && readout_protect |=> mem_rd_data == 8'hff)
    else $error("protected memory content leaked");
  a_write_blocked: assert property (age[1] && readout_protect |=> !mem_wr_allow)
    else $error("memory write allowed under protection");
  a_erase_fill: assert property (mem_erase |-> opt_busy && mem_erase_data == 8'hff)
    else $error("memory erase outside busy or not to erased value");
  a_erase_step: assert property (mem_erase && $past(mem_erase) |->
    mem_erase_addr == $past(mem_erase_addr) + 1'b1)
    else $error("erase address skipped");
  a_delay_codes: assert property (age[1] |-> reset_delay_cycles inside {13'h1000, 13'h0100})
    else $error("illegal delay length");
  a_pads_wide: assert property (age[1] && pkg_44pin |-> pad_pullup_force == '0)
    else $error("pull-up forced on bonded pads");
  a_pads_narrow: assert property (age[1] && !pkg_44pin |->
    $countones(pad_pullup_force) == PADS_PER_PORT)
    else $error("wrong count of unbonded pads");
  a_config_static: assert property (age == 2'h3 |-> $stable({wdg_hw_enable, pkg_44pin,
    reset_delay_cycles, clock_source_type, oscillator_range, pll_enable, readout_protect}))
    else $error("configuration changed between resets");
  c_erase: cover property (mem_erase [*4]);
  c_halt: cover property (halt_reset_req);
  c_narrow: cover property (age[1] && !pkg_44pin);
endmodule // obcd_checker
bind obcd_option_byte_config_decoder obcd_checker #(.MEM_ADDR_W(MEM_ADDR_W),
  .NUM_PORTS(NUM_PORTS)) u_chk (.*);

// ### verification/obcd_prog_tool.sv
// Programming tool model on the option byte access port
`timescale 1ns/1ns
module obcd_prog_tool (
  // Clock
  input  wire logic       clk,
  // Option port
  output logic            prog_mode,
  output logic            opt_wr,
  output logic            opt_sel,
  output logic [7:0]      opt_wdata,
  output logic            opt_erase,
  input  wire logic [7:0] opt_rdata
);
  initial begin
    {prog_mode, opt_wr, opt_sel, opt_erase} = 4'h0;
    opt_wdata = 8'h5a;
  end
  task automatic mode(input logic on);
    @(posedge clk);
    #1 prog_mode = on;
  endtask
  task automatic write(input logic sel, input logic [7:0] d);
    @(posedge clk);
    #1 opt_sel = sel;
    opt_wdata = sel ? d : (d | 8'h3e);
    opt_wr = 1'b1;
    @(posedge clk);
    #1 opt_wr = 1'b0;
    opt_wdata = ~opt_wdata;
  endtask
  task automatic erase();
    @(posedge clk);
    #1 opt_erase = 1'b1;
    @(posedge clk);
    #1 opt_erase = 1'b0;
  endtask
  // Answer is registered one cycle behind the select
  task automatic read(input logic sel, output logic [7:0] d);
    @(posedge clk);
    #1 opt_sel = sel;
    @(posedge clk);
    #1 d = opt_rdata;
  endtask
endmodule // obcd_prog_tool

// ### verification/tb_top.sv
// Self-checking bench for the option byte config decoder
`timescale 1ns/1ns
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin n_fail++; \
  $display("ERROR %s expected %h seen %h", n, e, a); end end
module tb_top;
  import obcd_pkg::*;
  localparam int AW = 4;
  logic clk, rst_n, prog_mode, opt_wr, opt_sel, opt_erase, opt_busy, mem_rd_ext, mem_wr_req;
  logic mem_wr_allow, mem_erase, halt_entry, wdg_active, halt_reset_req, wdg_hw_enable;
  logic pkg_44pin, pll_enable, readout_protect;
  logic [7:0]  opt_wdata, opt_rdata, mem_rd_raw, mem_rd_data, mem_erase_data, rd;
  logic [AW-1:0] mem_erase_addr;
  logic [12:0] reset_delay_cycles;
  logic [1:0]  clock_source_type;
  logic [2:0]  oscillator_range;
  logic [31:0] pad_pullup_force;
  logic [7:0]  cfg0 [4] = '{8'h7f, 8'hff, 8'hff, 8'hbe};
  // Resonator keeps the long delay; doubler only in the 2-4 MHz range
  logic [7:0]  cfg1 [4] = '{8'h02, 8'h87, 8'h31, 8'hf5};
  int n_fail, samples_checked, nb, ne;
  obcd_option_byte_config_decoder #(.MEM_ADDR_W(AW)) dut (.*);
  // Mask ROM variant on the same stimulus: its options must never move
  localparam logic [7:0] RB0 = 8'h3e;
  localparam logic [7:0] RB1 = 8'h32;
  logic        r_wdg, r_pkg, r_pll, r_rop;
  logic [12:0] r_delay;
  logic [1:0]  r_osc;
  logic [2:0]  r_range;
  logic [7:0]  r_rdata;
  obcd_option_byte_config_decoder #(.MASK_ROM(1'b1), .ROM_BYTE0(RB0), .ROM_BYTE1(RB1),
    .MEM_ADDR_W(AW)) dut_rom (.clk(clk), .rst_n(rst_n), .prog_mode(prog_mode), .opt_wr(opt_wr),
    .opt_sel(opt_sel), .opt_wdata(opt_wdata), .opt_erase(opt_erase), .opt_rdata(r_rdata),
    .opt_busy(), .mem_rd_ext(mem_rd_ext), .mem_wr_req(mem_wr_req), .mem_rd_raw(mem_rd_raw),
    .mem_rd_data(), .mem_wr_allow(), .mem_erase(), .mem_erase_addr(), .mem_erase_data(),
    .halt_entry(halt_entry), .wdg_active(wdg_active), .halt_reset_req(),
    .wdg_hw_enable(r_wdg), .pkg_44pin(r_pkg), .reset_delay_cycles(r_delay),
    .clock_source_type(r_osc), .oscillator_range(r_range), .pll_enable(r_pll),
    .readout_protect(r_rop), .pad_pullup_force());
  obcd_prog_tool tool (.clk(clk), .prog_mode(prog_mode), .opt_wr(opt_wr), .opt_sel(opt_sel),
    .opt_wdata(opt_wdata), .opt_erase(opt_erase), .opt_rdata(opt_rdata));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic do_reset(input int n);
    rst_n = 1'b0;
    tick(n);
    rst_n = 1'b1;
    tick(3);
  endtask
  task automatic check_cfg(input logic [7:0] b0, input logic [7:0] b1);
    `CHK("wdg_hw_enable", ~b0[6], wdg_hw_enable)
    `CHK("readout_protect", ~b0[0], readout_protect)
    `CHK("pkg_44pin", b1[7], pkg_44pin)
    `CHK("delay", b1[6] ? 13'h0100 : 13'h1000, reset_delay_cycles)
    `CHK("clock_source_type", b1[5:4], clock_source_type)
    `CHK("oscillator_range", b1[3:1], oscillator_range)
    `CHK("pll_enable", ~b1[0], pll_enable)
    `CHK("pad_pullup_force", b1[7] ? 32'h0 : 32'hf0f0_0000, pad_pullup_force)
  endtask
  task automatic check_rom();
    `CHK("rom byte0", ({~RB0[6], ~RB0[0]}), ({r_wdg, r_rop}))
    `CHK("rom delay", RB1[6] ? 13'h0100 : 13'h1000, r_delay)
    `CHK("rom byte1", ({RB1[7], RB1[5:1], ~RB1[0]}), ({r_pkg, r_osc, r_range, r_pll}))
  endtask
  task automatic close_out();
    $display("checked %0d failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    close_out();
  end
  initial begin
    {rst_n, mem_rd_ext, mem_wr_req, halt_entry, wdg_active} = 5'h0;
    mem_rd_raw = 8'h3c;
    n_fail = 0;
    samples_checked = 0;
    do_reset(16);
    check_cfg(FACTORY_BYTE0, FACTORY_BYTE1);
    `CHK("factory clock", OSC_INTERNAL, clock_source_type)
    `CHK("erase data", 8'hff, mem_erase_data)
    check_rom();
    tool.write(1'b1, 8'h00);
    tool.mode(1'b1);
    tool.read(1'b1, rd);
    `CHK("refused write", FACTORY_BYTE1, rd)
    foreach (cfg1[i]) begin
      tool.write(1'b0, cfg0[i]);
      tool.write(1'b1, cfg1[i]);
      tool.read(1'b1, rd);
      `CHK("byte1 readback", cfg1[i], rd)
      `CHK("rom read closed", 8'h00, r_rdata)
      tool.mode(1'b0);
      do_reset(2);
      check_cfg(cfg0[i], cfg1[i]);
      check_rom();
      {halt_entry, wdg_active, mem_rd_ext, mem_wr_req} = 4'hf;
      tick(1);
      {halt_entry, wdg_active, mem_rd_ext, mem_wr_req} = 4'h0;
      `CHK("halt reset", cfg0[i][7], halt_reset_req)
      `CHK("write gate", cfg0[i][0], mem_wr_allow)
      `CHK("read gate", cfg0[i][0] ? 8'h3c : 8'hff, mem_rd_data)
      tool.mode(1'b1);
    end
    tool.erase();
    nb = 0;
    ne = 0;
    for (int k = 0; k < 40; k++) begin
      nb += opt_busy;
      ne += mem_erase;
      tick(1);
    end
    `CHK("busy cycles", 2**AW + 1, nb)
    `CHK("erase pulses", 2**AW, ne)
    tool.read(1'b0, rd);
    `CHK("byte0 erased", 8'hff, rd)
    tool.read(1'b1, rd);
    `CHK("byte1 erased", 8'hff, rd)
    close_out();
  end
endmodule // tb_top
